// ===== zdc_regs.svh
`ifndef ZDC_REGS_SVH
`define ZDC_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ZDC_OFS_CTRL 8'h00
`define ZDC_OFS_ODIV 8'h04
`define ZDC_OFS_STAT 8'h08

// ---------------------------------------------------------------
// Control register fields and reset value
// ---------------------------------------------------------------
`define ZDC_CTRL_BPEN 0
`define ZDC_CTRL_PD_LO 1
`define ZDC_CTRL_PD_HI 2
`define ZDC_CTRL_PLLEN 3
`define ZDC_CTRL_FBSEL 4
`define ZDC_CTRL_MR 5
`define ZDC_CTRL_OE_LO 6
`define ZDC_CTRL_OE_HI 8
`define ZDC_CTRL_RST 9'h1c9
`define ZDC_ODIV_RST 8'h00

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define ZDC_STAT_BPRX 0
`define ZDC_STAT_FB 1
`define ZDC_STAT_MAIN_LO 2
`define ZDC_STAT_MAIN_HI 9
`define ZDC_STAT_MR 10
`define ZDC_STAT_BYP 11

// ---------------------------------------------------------------
// Divide values
// ---------------------------------------------------------------
`define ZDC_PD_DIV1 4'h1
`define ZDC_PD_DIV4 4'h4
`define ZDC_PD_DIV5 4'h5
`define ZDC_PD_DIV8 4'h8
`define ZDC_OD_LO 4'h5
`define ZDC_OD_HI 4'h4
`define ZDC_FB_LO 4'h4
`define ZDC_FB_HI 4'h5

// ---------------------------------------------------------------
// Output group enable decoding
// ---------------------------------------------------------------
`define ZDC_OE_ALL 3'h7
`define ZDC_OE_GRP0 8'h07
`define ZDC_OE_GRP1 8'h38
`define ZDC_OE_GRP2 8'hc0

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define ZDC_RESP_OKAY 2'h0
`define ZDC_RESP_SLVERR 2'h2

`endif

// ===== zdc_pkg.sv
package zdc_pkg;
  // Divide ratio of one counter stage
  typedef logic [3:0] zdc_div_t;
  // Reference predivider selection codes
  typedef enum logic [1:0] {
    ZDC_PD1,
    ZDC_PD4,
    ZDC_PD5,
    ZDC_PD8
  } zdc_pdsel_e;
endpackage

// ===== zdc_divider.sv
`timescale 1ns/100ps
`include "zdc_regs.svh"

// Tick-counting divider: one output tick per i_div input ticks
module zdc_divider (
  input wire logic i_ref_clk,               // System clock
  input wire logic i_srst,                  // Synchronous reset
  input wire logic i_clr,                   // Hold divider cleared
  input wire logic i_tick,                  // Source tick
  input wire zdc_pkg::zdc_div_t i_div,      // Divide ratio
  output logic o_tick,                      // Divided tick pulse
  output logic o_level,                     // Divided clock level
  output zdc_pkg::zdc_div_t o_cnt           // Current count
);

  zdc_pkg::zdc_div_t cnt_r;
  logic wrap;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Wrap on last count, or on the next tick if ratio shrank below count
  assign wrap = i_tick && (cnt_r >= (i_div - 4'h1));

  // Counter held at zero while cleared
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_clr) begin
      cnt_r <= 4'h0;
    end else if (wrap) begin
      cnt_r <= 4'h0;
    end else if (i_tick) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Tick pulse and toggling level
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_clr) begin
      o_tick <= 1'b0;
      o_level <= 1'b0;
    end else begin
      o_tick <= wrap;
      if (wrap) begin
        o_level <= ~o_level;
      end
    end
  end

  assign o_cnt = cnt_r;

endmodule // zdc_divider

// ===== zdc_ctrl.sv
`timescale 1ns/100ps
`include "zdc_regs.svh"

// Summary of operation
// - Drive enable high: backplane pair driven with predivided reference clock.
// - Backplane frequency is reference divided by predivider 1, 4, 5 or 8.
// - Drive enable low: backplane driver high impedance, pair used as input.
// - Loop select picks bypass or enabled; enabled outputs are VCO over divider.
// - Bypass outputs are reference over predivider times output divider.
// - Feedback divider select low gives divide by 4, high divide by 5.
// - Master reset holds dividers cleared and true main outputs high impedance.
// - Master reset overrides the output group enable field.
// - Master reset low: dividers run, main outputs follow group enable field.
// - Three enable bits select switching pairs; default all pairs switch.
// - Feedback output pair toggles regardless of group enable field.
// - Undriven controls default to their pull-up or pull-down level.
// - Each main pair has its own output divider select.
module zdc_ctrl (
  input wire logic i_ref_clk,               // System clock, one reference period
  input wire logic i_srst,                  // Synchronous reset
  input wire logic i_vco_tick,              // One pulse per VCO period
  input wire logic i_bp_true,               // Backplane true pin, input side
  input wire logic i_bp_inv,                // Backplane inverted pin, input side
  output logic o_bp_true,                   // Backplane true pin, output side
  output logic o_bp_true_oe,                // Backplane true pin drive enable
  output logic o_bp_inv,                    // Backplane inverted pin, output side
  output logic o_bp_inv_oe,                 // Backplane inverted pin drive enable
  output logic [7:0] o_main_true,           // Main clock outputs, true
  output logic [7:0] o_main_true_oe,        // Main true drive enables
  output logic [7:0] o_main_inv,            // Main clock outputs, inverted
  output logic o_fb_true,                   // Feedback clock out, true
  output logic o_fb_inv,                    // Feedback clock out, inverted
  input wire logic [7:0] i_s_axi_awaddr,    // Write address
  input wire logic i_s_axi_awvalid,         // Write address valid
  output logic o_s_axi_awready,             // Write address ready
  input wire logic [31:0] i_s_axi_wdata,    // Write data
  input wire logic [3:0] i_s_axi_wstrb,     // Write byte strobes
  input wire logic i_s_axi_wvalid,          // Write data valid
  output logic o_s_axi_wready,              // Write data ready
  output logic [1:0] o_s_axi_bresp,         // Write response
  output logic o_s_axi_bvalid,              // Write response valid
  input wire logic i_s_axi_bready,          // Write response ready
  input wire logic [7:0] i_s_axi_araddr,    // Read address
  input wire logic i_s_axi_arvalid,         // Read address valid
  output logic o_s_axi_arready,             // Read address ready
  output logic [31:0] o_s_axi_rdata,        // Read data
  output logic [1:0] o_s_axi_rresp,         // Read response
  output logic o_s_axi_rvalid,              // Read data valid
  input wire logic i_s_axi_rready           // Read data ready
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [8:0] ctrl_r;
  logic [7:0] odiv_r;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic commit;
  logic [31:0] wmask;
  logic [31:0] ctrl_merged;
  logic [31:0] odiv_merged;
  logic [31:0] stat_word;
  logic ctrl_bpen;
  logic ctrl_pllen;
  logic ctrl_fbsel;
  logic ctrl_mr;
  logic [2:0] ctrl_oe;
  zdc_pkg::zdc_pdsel_e pd_sel;
  zdc_pkg::zdc_div_t pd_div;
  logic pd_tick;
  logic pd_level;
  logic src_tick_r;
  logic fb_level;
  zdc_pkg::zdc_div_t fb_cnt;
  logic [7:0] main_level;
  logic [7:0] grp_en;
  zdc_pkg::zdc_div_t main_cnt [7:0];

  // ---------------------------------------------------------------
  // Control field decode
  // ---------------------------------------------------------------
  assign ctrl_bpen = ctrl_r[`ZDC_CTRL_BPEN];
  assign ctrl_pllen = ctrl_r[`ZDC_CTRL_PLLEN];
  assign ctrl_fbsel = ctrl_r[`ZDC_CTRL_FBSEL];
  assign ctrl_mr = ctrl_r[`ZDC_CTRL_MR];
  assign ctrl_oe = ctrl_r[`ZDC_CTRL_OE_HI:`ZDC_CTRL_OE_LO];
  assign pd_sel = zdc_pkg::zdc_pdsel_e'(ctrl_r[`ZDC_CTRL_PD_HI:`ZDC_CTRL_PD_LO]);

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  // Write lands once both address and data are held
  assign commit = aw_have_r && w_have_r && !o_s_axi_bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign ctrl_merged = ({23'h0, ctrl_r} & ~wmask) | (w_data_r & wmask);
  assign odiv_merged = ({24'h0, odiv_r} & ~wmask) | (w_data_r & wmask);

  // Write address capture
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_s_axi_awready <= 1'b0;
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      o_s_axi_awready <= 1'b0;
      aw_have_r <= 1'b1;
      aw_addr_r <= i_s_axi_awaddr;
    end else if (commit) begin
      aw_have_r <= 1'b0;
    end else if (!aw_have_r && !o_s_axi_bvalid) begin
      o_s_axi_awready <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_s_axi_wready <= 1'b0;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      o_s_axi_wready <= 1'b0;
      w_have_r <= 1'b1;
      w_data_r <= i_s_axi_wdata;
      w_strb_r <= i_s_axi_wstrb;
    end else if (commit) begin
      w_have_r <= 1'b0;
    end else if (!w_have_r && !o_s_axi_bvalid) begin
      o_s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `ZDC_RESP_OKAY;
    end else if (commit) begin
      o_s_axi_bvalid <= 1'b1;
      if (aw_addr_r == `ZDC_OFS_CTRL || aw_addr_r == `ZDC_OFS_ODIV ||
          aw_addr_r == `ZDC_OFS_STAT) begin
        o_s_axi_bresp <= `ZDC_RESP_OKAY;
      end else begin
        o_s_axi_bresp <= `ZDC_RESP_SLVERR;
      end
    end else if (o_s_axi_bready_taken()) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic o_s_axi_bready_taken();
    return o_s_axi_bvalid && i_s_axi_bready;
  endfunction

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Reset values mirror the pin pull defaults
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_r <= `ZDC_CTRL_RST;
      odiv_r <= `ZDC_ODIV_RST;
    end else if (commit && aw_addr_r == `ZDC_OFS_CTRL) begin
      ctrl_r <= ctrl_merged[8:0];
    end else if (commit && aw_addr_r == `ZDC_OFS_ODIV) begin
      odiv_r <= odiv_merged[7:0];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  // Status view of live block state
  always_comb begin
    stat_word = 32'h0;
    stat_word[`ZDC_STAT_BPRX] = !ctrl_bpen && i_bp_true && !i_bp_inv;
    stat_word[`ZDC_STAT_FB] = fb_level;
    stat_word[`ZDC_STAT_MAIN_HI:`ZDC_STAT_MAIN_LO] = main_level;
    stat_word[`ZDC_STAT_MR] = ctrl_mr;
    stat_word[`ZDC_STAT_BYP] = !ctrl_pllen;
  end

  // Read address and data
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= `ZDC_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= `ZDC_RESP_OKAY;
      case (i_s_axi_araddr)
        `ZDC_OFS_CTRL: o_s_axi_rdata <= {23'h0, ctrl_r};
        `ZDC_OFS_ODIV: o_s_axi_rdata <= {24'h0, odiv_r};
        `ZDC_OFS_STAT: o_s_axi_rdata <= stat_word;
        default: begin
          o_s_axi_rdata <= 32'h0;
          o_s_axi_rresp <= `ZDC_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end else if (!o_s_axi_rvalid) begin
      o_s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Reference predivider and backplane pair
  // ---------------------------------------------------------------
  // Predivider ratio from its selection code
  always_comb begin
    case (pd_sel)
      zdc_pkg::ZDC_PD1: pd_div = `ZDC_PD_DIV1;
      zdc_pkg::ZDC_PD4: pd_div = `ZDC_PD_DIV4;
      zdc_pkg::ZDC_PD5: pd_div = `ZDC_PD_DIV5;
      zdc_pkg::ZDC_PD8: pd_div = `ZDC_PD_DIV8;
      default: pd_div = `ZDC_PD_DIV1;
    endcase
  end

  // Every reference period is one source tick
  zdc_divider u_prediv (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_clr(ctrl_mr),
    .i_tick(1'b1),
    .i_div(pd_div),
    .o_tick(pd_tick),
    .o_level(pd_level),
    .o_cnt()
  );

  // Backplane driver, released to input when disabled
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_bp_true <= 1'b0;
      o_bp_inv <= 1'b0;
      o_bp_true_oe <= 1'b0;
      o_bp_inv_oe <= 1'b0;
    end else begin
      o_bp_true <= pd_level;
      o_bp_inv <= ~pd_level;
      o_bp_true_oe <= ctrl_bpen;
      o_bp_inv_oe <= ctrl_bpen;
    end
  end

  // ---------------------------------------------------------------
  // Loop source selection
  // ---------------------------------------------------------------
  // VCO ticks when enabled, predivided reference in bypass
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      src_tick_r <= 1'b0;
    end else begin
      src_tick_r <= ctrl_pllen ? i_vco_tick : pd_tick;
    end
  end

  // ---------------------------------------------------------------
  // Feedback output divider
  // ---------------------------------------------------------------
  zdc_divider u_fbdiv (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_clr(ctrl_mr),
    .i_tick(src_tick_r),
    .i_div(ctrl_fbsel ? `ZDC_FB_HI : `ZDC_FB_LO),
    .o_tick(),
    .o_level(fb_level),
    .o_cnt(fb_cnt)
  );

  // Feedback pair ignores the group enables
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_fb_true <= 1'b0;
      o_fb_inv <= 1'b0;
    end else begin
      o_fb_true <= fb_level;
      o_fb_inv <= ~fb_level;
    end
  end

  // ---------------------------------------------------------------
  // Main output dividers and enables
  // ---------------------------------------------------------------
  // Group enable decode, master reset wins
  assign grp_en = ctrl_mr ? 8'h00 :
                  (({8{ctrl_oe[0]}} & `ZDC_OE_GRP0) |
                   ({8{ctrl_oe[1]}} & `ZDC_OE_GRP1) |
                   ({8{ctrl_oe[2]}} & `ZDC_OE_GRP2));

  for (genvar k = 0; k < 8; k++) begin : g_main
    // Own divider per pair
    zdc_divider u_odiv (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_clr(ctrl_mr),
      .i_tick(src_tick_r),
      .i_div(odiv_r[k] ? `ZDC_OD_HI : `ZDC_OD_LO),
      .o_tick(),
      .o_level(main_level[k]),
      .o_cnt(main_cnt[k])
    );

    // Pair drive, true side floats when disabled
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        o_main_true[k] <= 1'b0;
        o_main_true_oe[k] <= 1'b0;
        o_main_inv[k] <= 1'b0;
      end else begin
        o_main_true[k] <= main_level[k];
        o_main_true_oe[k] <= grp_en[k];
        o_main_inv[k] <= grp_en[k] & ~main_level[k];
      end
    end

    property p_odiv_bound;
      @(posedge i_ref_clk) disable iff (i_srst)
        (!odiv_r[k] ##1 !odiv_r[k]) |-> main_cnt[k] < `ZDC_OD_LO;
    endproperty
    a_odiv_bound: assert property (p_odiv_bound)
      else $error("main divider count exceeds its ratio");
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_pd8_run;
    (pd_sel == zdc_pkg::ZDC_PD8 && !ctrl_mr)[*8];
  endsequence
  sequence s_bypass_run;
    (!ctrl_pllen && !ctrl_mr && pd_sel == zdc_pkg::ZDC_PD1)[*8];
  endsequence

  property p_bp_drive;
    ctrl_bpen |=> o_bp_true_oe && o_bp_inv_oe && (o_bp_inv == ~o_bp_true);
  endproperty
  a_bp_drive: assert property (p_bp_drive)
    else $error("backplane pair not driven while enabled");

  property p_bp_hiz;
    !ctrl_bpen |=> !o_bp_true_oe && !o_bp_inv_oe;
  endproperty
  a_bp_hiz: assert property (p_bp_hiz)
    else $error("backplane driver active while disabled");

  property p_pd8;
    (pd_tick && pd_sel == zdc_pkg::ZDC_PD8) ##1 s_pd8_run |-> pd_tick;
  endproperty
  a_pd8: assert property (p_pd8)
    else $error("predivide by 8 spacing wrong");

  property p_pll_src;
    (ctrl_pllen && !i_vco_tick) |=> !src_tick_r;
  endproperty
  a_pll_src: assert property (p_pll_src)
    else $error("source tick without VCO tick");

  property p_byp_src;
    !ctrl_pllen |=> src_tick_r == $past(pd_tick);
  endproperty
  a_byp_src: assert property (p_byp_src)
    else $error("bypass source is not the predivided reference");

  property p_fb_div4;
    // A shrunk ratio only wraps on a source tick, so check after one
    (!ctrl_fbsel && src_tick_r) |=> fb_cnt < `ZDC_FB_LO;
  endproperty
  a_fb_div4: assert property (p_fb_div4)
    else $error("feedback divider beyond divide by 4");

  property p_mr_hiz;
    ctrl_mr |=> o_main_true_oe == 8'h00 && fb_cnt == 4'h0;
  endproperty
  a_mr_hiz: assert property (p_mr_hiz)
    else $error("main outputs driven under master reset");

  property p_oe_all;
    (!ctrl_mr && ctrl_oe == `ZDC_OE_ALL) |=> o_main_true_oe == 8'hff;
  endproperty
  a_oe_all: assert property (p_oe_all)
    else $error("not all pairs enabled for all-ones code");

  property p_oe_grp0;
    (!ctrl_mr && !ctrl_oe[0]) |=> (o_main_true_oe & `ZDC_OE_GRP0) == 8'h00;
  endproperty
  a_oe_grp0: assert property (p_oe_grp0)
    else $error("group 0 pairs enabled with its bit low");

  property p_fb_runs;
    s_bypass_run |-> ##[1:12] $changed(o_fb_true);
  endproperty
  a_fb_runs: assert property (p_fb_runs)
    else $error("feedback output not toggling");

  property p_defaults;
    $past(i_srst) |-> ctrl_r == `ZDC_CTRL_RST && odiv_r == `ZDC_ODIV_RST;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("control defaults wrong after reset");

endmodule // zdc_ctrl

// ===== zdc_far.sv
`timescale 1ns/100ps

// Far side: VCO pulse source and remote backplane clock driver
module zdc_far #(
  parameter int GAP = 3
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_lvl, // Remote backplane level
  output logic o_vco_tick, // One pulse per VCO period
  output logic o_bp_true, // Remote true drive
  output logic o_bp_inv // Remote inverted drive
);
  int cnt_r;

  // VCO pulse every GAP cycles
  always_ff @(posedge i_ref_clk) begin
    cnt_r <= (i_srst || cnt_r == GAP - 1) ? 0 : cnt_r + 1;
  end
  assign o_vco_tick = (cnt_r == GAP - 1);

  // Remote source drives a complementary pair
  assign o_bp_true = i_lvl;
  assign o_bp_inv = ~i_lvl;
endmodule // zdc_far

// ===== zdc_ctrl_tb.sv
`timescale 1ns/100ps
`include "zdc_regs.svh"

module zdc_ctrl_tb;
  logic clk = 0, srst = 1, lvl = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, vco, bp_t, bp_i;
  logic bpt_o, bpi_o, bpt_oe, bpi_oe, ft, fi, ft_far, fi_far;
  logic [7:0] mt, mt_oe, mi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0, total_checks = 0;
  logic [8:0] ctrl_m; // Model of control settings
  logic [7:0] odiv_m; // Model of divider selects

  always #5 clk = ~clk;

  zdc_far #(.GAP(3)) u_zdc_far (.i_ref_clk(clk), .i_srst(srst), .i_lvl(lvl),
    .o_vco_tick(vco), .o_bp_true(ft_far), .o_bp_inv(fi_far));

  // Wire level of the two-way backplane pair
  assign bp_t = bpt_oe ? bpt_o : ft_far;
  assign bp_i = bpi_oe ? bpi_o : fi_far;

  zdc_ctrl u_zdc_ctrl (.i_ref_clk(clk), .i_srst(srst), .i_vco_tick(vco),
    .i_bp_true(bp_t), .i_bp_inv(bp_i), .o_bp_true(bpt_o), .o_bp_true_oe(bpt_oe),
    .o_bp_inv(bpi_o), .o_bp_inv_oe(bpi_oe), .o_main_true(mt), .o_main_true_oe(mt_oe),
    .o_main_inv(mi), .o_fb_true(ft), .o_fb_inv(fi), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready));

  // Verdict and end of run
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Clock period comparison
  task automatic chk_gap(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %0t period %0d exp %0d", $time, got, exp);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    d = '1;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Control write with model update and settle time
  task automatic setc(input logic [8:0] c);
    logic [1:0] r;
    ctrl_m = c;
    wr(`ZDC_OFS_CTRL, {23'h0, c}, r);
    chk({30'h0, r}, 32'h0);
    repeat (3) @(posedge clk);
  endtask

  function automatic logic pin(input int s);
    return s == 0 ? bpt_o : s == 1 ? ft : mt[s-2];
  endfunction

  // Cycles between toggles, after two toggles to let a ratio change settle
  task automatic gap(input int s, output int g);
    logic p;
    int k;
    for (k = 0; k < 3; k++) begin
      p = pin(s);
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (pin(s) === p && g < 400);
    end
  endtask

  function automatic int pdv(input logic [8:0] c);
    return c[2:1] == 0 ? 1 : c[2:1] == 1 ? 4 : c[2:1] == 2 ? 5 : 8;
  endfunction

  // Source ticks: VCO every 3 cycles, else predivided reference
  function automatic int src(input logic [8:0] c);
    return c[3] ? 3 : pdv(c);
  endfunction

  function automatic logic [7:0] oe_x(input logic [8:0] c);
    return c[5] ? 8'h00 : {{2{c[8]}}, {3{c[7]}}, {3{c[6]}}};
  endfunction

  // Watchdog
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int g, i, k;
    void'($urandom(32'h5615bf62));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    ctrl_m = 9'h1c9;
    odiv_m = 8'h00;
    rd(`ZDC_OFS_CTRL, d, r);
    chk(d, {23'h0, ctrl_m});
    rd(`ZDC_OFS_ODIV, d, r);
    chk(d, {24'h0, odiv_m});
    chk({30'h0, bpt_oe, bpi_oe}, 32'h3);
    rd(8'h0c, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(8'h10, 32'h0, r);
    chk({30'h0, r}, 32'h2);
    wr(`ZDC_OFS_STAT, 32'hffff_ffff, r);
    chk({30'h0, r}, 32'h0);
    setc(9'h1e9);
    repeat (10) @(posedge clk);
    chk({mt_oe, mi, 14'h0, ft, fi}, 32'h1);
    setc(9'h1c9);
    chk({24'h0, mt_oe}, 32'hff);
    for (k = 0; k < 8; k++) begin
      odiv_m = 8'($urandom);
      wr(`ZDC_OFS_ODIV, {24'h0, odiv_m}, r);
      setc({3'h7, 1'b0, k[2], 1'($urandom), k[1:0], 1'b1});
      i = $urandom_range(7);
      gap(i + 2, g);
      chk_gap(g, src(ctrl_m) * (odiv_m[i] ? 4 : 5));
      chk({30'h0, mi[i], fi}, {30'h0, ~mt[i], ~ft});
      gap(1, g);
      chk_gap(g, src(ctrl_m) * (ctrl_m[4] ? 5 : 4));
      gap(0, g);
      chk_gap(g, pdv(ctrl_m));
      chk({31'h0, bpi_o}, {31'h0, ~bpt_o});
      rd(`ZDC_OFS_STAT, d, r);
      chk({31'h0, d[11]}, {31'h0, ~ctrl_m[3]});
    end
    for (k = 0; k < 8; k++) begin
      setc({k[2:0], 6'h09});
      chk({24'h0, mt_oe}, {24'h0, oe_x(ctrl_m)});
      chk({24'h0, mi & ~mt_oe}, 32'h0);
      setc({k[2:0], 6'h29});
      chk({24'h0, mt_oe}, 32'h0);
    end
    setc(9'h1c8);
    chk({30'h0, bpt_oe, bpi_oe}, 32'h0);
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      lvl <= k[0];
      repeat (3) @(posedge clk);
      rd(`ZDC_OFS_STAT, d, r);
      chk({31'h0, d[0]}, {31'h0, k[0]});
    end
    wrap_up();
  end
endmodule // zdc_ctrl_tb
